// ===== design/see_defs.svh
// Constants for the serial EEPROM instruction engine: codes, sizes and timing counts.
// Assumes the includer compiles it once per unit; guarded against double inclusion.
`ifndef SEE_DEFS_SVH
`define SEE_DEFS_SVH

`define SEE_CLK_MHZ 20
`define SEE_WORDS 64
`define SEE_ADDR_W 6
`define SEE_DATA_W 16
`define SEE_CMD_BITS 5'h08
`define SEE_DATA_BITS 5'h10
`define SEE_CNT_W 19

`define SEE_OP_READ 2'h2
`define SEE_OP_WRITE 2'h1
`define SEE_OP_ERASE 2'h3
`define SEE_OP_EXT 2'h0
`define SEE_EXT_ENABLE 2'h3
`define SEE_EXT_DISABLE 2'h0
`define SEE_EXT_ERASE_ALL 2'h2
`define SEE_EXT_WRITE_ALL 2'h1

`define SEE_ERASED_WORD 16'hFFFF
`define SEE_RESET_WORD 16'h0000

`define SEE_WRITE_TIME_US 2000
`define SEE_ERASE_TIME_US 1000
`define SEE_ALL_TIME_US 15000
`define SEE_WRITE_CYC (`SEE_WRITE_TIME_US * `SEE_CLK_MHZ)
`define SEE_ERASE_CYC (`SEE_ERASE_TIME_US * `SEE_CLK_MHZ)
`define SEE_ALL_CYC (`SEE_ALL_TIME_US * `SEE_CLK_MHZ)

`endif

// ===== design/see_pkg.sv
// Types for the serial EEPROM instruction engine.
// Assumes see_defs.svh is on the include path.
`include "see_defs.svh"

package see_pkg;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b000,
      ST_CMD = 3'b001,
      ST_DATA = 3'b010,
      ST_READ = 3'b011,
      ST_DONE = 3'b100
   } see_state_t;

   typedef enum logic [2:0] {
      CMD_NONE = 3'b000,
      CMD_READ = 3'b001,
      CMD_WRITE = 3'b010,
      CMD_ERASE = 3'b011,
      CMD_ENABLE = 3'b100,
      CMD_DISABLE = 3'b101,
      CMD_ERASE_ALL = 3'b110,
      CMD_WRITE_ALL = 3'b111
   } see_cmd_t;

   typedef logic [`SEE_CNT_W-1:0] see_count_t;
   typedef logic [`SEE_ADDR_W-1:0] see_addr_t;
   typedef logic [`SEE_DATA_W-1:0] see_word_t;

endpackage : see_pkg

// ===== design/see_prog_timer.sv
// Self-timed programming cycle counter.
// Assumes start is a one-cycle pulse and cycles is at least one.
`timescale 1ns/100ps

module see_prog_timer (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic start,
   input wire see_pkg::see_count_t cycles,
   output logic busy,
   output logic done
);
   import see_pkg::*;

   typedef struct packed {
      logic busy;
      see_count_t cnt;
   } see_tmr_t;

   see_tmr_t q;
   see_tmr_t d;

   always_comb begin
      d = q;
      done = q.busy && (q.cnt == '0);
      if (done) begin
         d.busy = 1'b0;
      end else if (q.busy) begin
         d.cnt = q.cnt - see_count_t'(1);
      end
      if (start && !q.busy) begin
         d.busy = 1'b1;
         d.cnt = cycles - see_count_t'(1);
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   assign busy = q.busy;

endmodule : see_prog_timer

// ===== design/see_engine.sv
// Instruction engine of a 64 x 16 serial EEPROM with self-timed programming.
// Assumes chip_sel, serial_clk and serial_data_in are synchronous to ref_clk and
// that serial_clk is slow enough for each level to be seen on at least one edge.
`timescale 1ns/100ps
`include "see_defs.svh"

// Behaviour
// - Read sends one zero dummy bit, then the sixteen addressed data bits.
// - Dummy bit is driven right after the edge capturing the address lsb.
// - Output floats on the edge after data lsb or when select drops.
// - Output bit holds steady between clock edges while select is high.
// - Read data leaves most significant bit first, descending to bit zero.
// - Word write erases the target word first, then programs new data.
// - Word program runs on internal timing from the last data edge.
// - Single word write with its erase finishes within two milliseconds.
// - Word erase sets the addressed word to ones after its last address bit.
// - Single word erase finishes within one millisecond.
// - Programming starts disabled; erase and write commands ignored until enabled.
// - Enabled erase-all sets whole array to ones after last dummy address bit.
// - Whole array erase finishes within fifteen milliseconds.
// - Write-all programs its word everywhere from last data edge within 15 ms.
// - Write-all has no pre-erase; host precedes it with erase-all, both enabled.
// - Start is the first rising clock with select and data input high; the code ignores it while programming is busy.
// - All bits are captured and launched on rising serial clock edges.
// - Select low resets control logic; a started program cycle still finishes.
// - Reselect during programming drives output low while busy, high when ready.
module see_engine #(
   parameter see_pkg::see_count_t WRITE_CYCLES = see_pkg::see_count_t'(`SEE_WRITE_CYC),
   parameter see_pkg::see_count_t ERASE_CYCLES = see_pkg::see_count_t'(`SEE_ERASE_CYC),
   parameter see_pkg::see_count_t ALL_CYCLES = see_pkg::see_count_t'(`SEE_ALL_CYC)
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic chip_sel,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   output logic serial_data_out,
   output logic serial_data_oe
);
   import see_pkg::*;

   typedef struct packed {
      see_state_t state;
      logic [4:0] bit_cnt;
      see_word_t in_shift;
      see_word_t out_shift;
      logic dout;
      logic oe;
      logic enabled;
      logic sclk_prev;
      logic status_arm;
      see_cmd_t prog_cmd;
      see_addr_t prog_addr;
      see_word_t prog_data;
   } see_eng_t;

   see_eng_t q;
   see_eng_t d;
   see_word_t mem [`SEE_WORDS];

   logic sclk_rise;
   logic busy;
   logic done;
   logic prog_start;
   see_count_t prog_cycles;
   see_cmd_t cmd;
   see_addr_t cmd_addr;
   see_word_t in_next;

   // Opcode and top address bits to a command
   function automatic see_cmd_t decode_cmd(input logic [7:0] bits);
      see_cmd_t c;
      c = CMD_NONE;
      case (bits[7:6])
         `SEE_OP_READ: c = CMD_READ;
         `SEE_OP_WRITE: c = CMD_WRITE;
         `SEE_OP_ERASE: c = CMD_ERASE;
         default: begin
            case (bits[5:4])
               `SEE_EXT_ENABLE: c = CMD_ENABLE;
               `SEE_EXT_DISABLE: c = CMD_DISABLE;
               `SEE_EXT_ERASE_ALL: c = CMD_ERASE_ALL;
               default: c = CMD_WRITE_ALL;
            endcase
         end
      endcase
      return c;
   endfunction : decode_cmd

   // Cycle budget of each programming command
   function automatic see_count_t cycles_of(input see_cmd_t c);
      see_count_t n;
      n = ERASE_CYCLES;
      case (c)
         CMD_WRITE: n = WRITE_CYCLES;
         CMD_ERASE: n = ERASE_CYCLES;
         CMD_ERASE_ALL: n = ALL_CYCLES;
         CMD_WRITE_ALL: n = ALL_CYCLES;
         default: n = ERASE_CYCLES;
      endcase
      return n;
   endfunction : cycles_of

   assign sclk_rise = serial_clk && !q.sclk_prev;
   assign in_next = {q.in_shift[14:0], serial_data_in};
   assign cmd = decode_cmd(in_next[7:0]);
   assign cmd_addr = in_next[5:0];

   always_comb begin
      d = q;
      prog_start = 1'b0;
      prog_cycles = cycles_of(q.prog_cmd);
      d.sclk_prev = serial_clk;
      if (!chip_sel) begin
         d.state = ST_IDLE;
         d.bit_cnt = '0;
         d.oe = 1'b0;
         d.dout = 1'b0;
         if (busy) begin
            d.status_arm = 1'b1;
         end
      end else begin
         case (q.state)
            ST_IDLE: begin
               d.oe = q.status_arm;
               d.dout = q.status_arm && !busy;
               if (sclk_rise && serial_data_in && !busy) begin
                  d.state = ST_CMD;
                  d.bit_cnt = '0;
                  d.status_arm = 1'b0;
                  d.oe = 1'b0;
                  d.dout = 1'b0;
               end
            end
            ST_CMD: begin
               if (sclk_rise) begin
                  d.in_shift = in_next;
                  d.bit_cnt = q.bit_cnt + 5'h01;
                  if (q.bit_cnt == `SEE_CMD_BITS - 5'h01) begin
                     d.bit_cnt = '0;
                     d.state = ST_DONE;
                     d.prog_addr = cmd_addr;
                     case (cmd)
                        CMD_READ: begin
                           d.out_shift = mem[cmd_addr];
                           d.dout = 1'b0;
                           d.oe = 1'b1;
                           d.state = ST_READ;
                        end
                        CMD_WRITE, CMD_WRITE_ALL: begin
                           d.state = ST_DATA;
                           d.prog_cmd = cmd;
                        end
                        CMD_ERASE, CMD_ERASE_ALL: begin
                           if (q.enabled) begin
                              d.prog_cmd = cmd;
                              prog_start = 1'b1;
                              prog_cycles = cycles_of(cmd);
                           end
                        end
                        CMD_ENABLE: begin
                           d.enabled = 1'b1;
                        end
                        CMD_DISABLE: begin
                           d.enabled = 1'b0;
                        end
                        default: begin
                           d.state = ST_DONE;
                        end
                     endcase
                  end
               end
            end
            ST_DATA: begin
               if (sclk_rise) begin
                  d.in_shift = in_next;
                  d.bit_cnt = q.bit_cnt + 5'h01;
                  if (q.bit_cnt == `SEE_DATA_BITS - 5'h01) begin
                     d.state = ST_DONE;
                     d.prog_data = in_next;
                     if (q.enabled) begin
                        prog_start = 1'b1;
                        prog_cycles = cycles_of(q.prog_cmd);
                     end
                  end
               end
            end
            ST_READ: begin
               if (sclk_rise) begin
                  if (q.bit_cnt == `SEE_DATA_BITS) begin
                     d.oe = 1'b0;
                     d.dout = 1'b0;
                     d.state = ST_DONE;
                  end else begin
                     d.dout = q.out_shift[15];
                     d.out_shift = {q.out_shift[14:0], 1'b0};
                     d.bit_cnt = q.bit_cnt + 5'h01;
                  end
               end
            end
            ST_DONE: begin
               d.state = ST_DONE;
            end
            default: begin
               d.state = ST_IDLE;
            end
         endcase
      end
   end

   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // Array updates: word write pre-erases at start, data lands at the end
   always_ff @(posedge ref_clk) begin
      if (prog_start && d.prog_cmd == CMD_WRITE) begin
         mem[d.prog_addr] <= `SEE_ERASED_WORD;
      end
      if (done) begin
         case (q.prog_cmd)
            CMD_WRITE: mem[q.prog_addr] <= q.prog_data;
            CMD_ERASE: mem[q.prog_addr] <= `SEE_ERASED_WORD;
            CMD_ERASE_ALL: begin
               for (int i = 0; i < `SEE_WORDS; i++) begin
                  mem[i] <= `SEE_ERASED_WORD;
               end
            end
            CMD_WRITE_ALL: begin
               for (int i = 0; i < `SEE_WORDS; i++) begin
                  mem[i] <= mem[i] & q.prog_data;
               end
            end
            default: begin
            end
         endcase
      end
   end

   see_prog_timer u_timer (
      .ref_clk(ref_clk),
      .reset_n(reset_n),
      .start(prog_start),
      .cycles(prog_cycles),
      .busy(busy),
      .done(done)
   );

   assign serial_data_out = q.dout;
   assign serial_data_oe = q.oe;

endmodule : see_engine

// ===== testbench/see_host.sv
// Host model: bus master driving select, serial clock and data in.
// Assumes a free-running ref_clk; the serial clock stays low between frames.
`timescale 1ns/100ps
module see_host (
   input wire logic ref_clk,
   output logic chip_sel,
   output logic serial_clk,
   output logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic serial_data_oe
);
   initial begin
      chip_sel = 1'b0;
      serial_clk = 1'b0;
      serial_data_in = 1'b0;
   end
   // Selects, then sends n bits from v[31] down, sampling output after each rise
   task automatic shift(input logic [31:0] v, input int n, output logic [31:0] dq,
         output logic [31:0] eq);
      dq = '0;
      eq = '0;
      chip_sel <= 1'b1;
      for (int i = 31; i > 31 - n; i--) begin
         @(posedge ref_clk);
         serial_clk <= 1'b0;
         serial_data_in <= v[i];
         repeat (3) @(posedge ref_clk);
         serial_clk <= 1'b1;
         repeat (3) @(posedge ref_clk);
         #1;
         dq[i] = serial_data_out;
         eq[i] = serial_data_oe;
      end
   endtask : shift
   // Deselects; data in no longer holds its last value
   task automatic drop();
      @(posedge ref_clk);
      serial_clk <= 1'b0;
      serial_data_in <= ~serial_data_in;
      chip_sel <= 1'b0;
      repeat (3) @(posedge ref_clk);
   endtask : drop
endmodule : see_host

// ===== testbench/see_engine_chk.sv
// Checker on the engine ports.
// Assumes the serial clock is low when reset is released.
`timescale 1ns/100ps
module see_engine_chk #(
   parameter see_pkg::see_count_t ALL_CYCLES = 19'h32
) (
   input wire logic ref_clk,
   input wire logic reset_n,
   input wire logic chip_sel,
   input wire logic serial_clk,
   input wire logic serial_data_in,
   input wire logic serial_data_out,
   input wire logic serial_data_oe
);
   import see_pkg::*;
   localparam int LIM = int'(ALL_CYCLES) + 4;
   logic sclk_q;
   logic [4:0] cnt;
   logic [1:0] op;
   int stat_cnt;
   wire sedge = chip_sel && serial_clk && !sclk_q;
   wire rd = (op == 2'h2);
   wire stat = chip_sel && (cnt == 5'h00) && serial_data_oe;
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         sclk_q <= 1'b0;
         cnt <= 5'h00;
         op <= 2'h0;
         stat_cnt <= 0;
      end else begin
         sclk_q <= serial_clk;
         stat_cnt <= (stat && !serial_data_out) ? stat_cnt + 1 : 0;
         if (!chip_sel) begin
            cnt <= 5'h00;
         end else if (sedge && (cnt != 5'h00 || serial_data_in) && cnt != 5'h1F) begin
            cnt <= cnt + 5'h01;
            if (cnt == 5'h01 || cnt == 5'h02) begin
               op <= {op[0], serial_data_in};
            end
         end
      end
   end
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!reset_n);
   sequence s_addr_done;
      sedge && rd && cnt == 5'h08;
   endsequence
   sequence s_last_out;
      sedge && rd && cnt == 5'h19;
   endsequence
   a_dummy_zero: assert property (s_addr_done |=> serial_data_oe && !serial_data_out)
      else $error("dummy bit missing");
   a_read_float: assert property (s_last_out |=> !serial_data_oe)
      else $error("output still driven after last bit");
   a_desel_float: assert property (!chip_sel |=> !serial_data_oe)
      else $error("output driven while deselected");
   a_read_hold: assert property (chip_sel && rd && cnt > 5'h09 && cnt < 5'h1A && !sedge
      |=> $stable(serial_data_out) && serial_data_oe) else $error("read bit not held");
   a_read_drive: assert property (sedge && rd && cnt > 5'h07 && cnt < 5'h18
      |=> serial_data_oe) else $error("read output dropped early");
   a_other_quiet: assert property (chip_sel && cnt != 5'h00 && !rd |=> !serial_data_oe)
      else $error("output driven outside read");
   a_ready_bound: assert property (stat_cnt <= LIM)
      else $error("busy status too long");
   a_ready_stays: assert property (stat && serial_data_out && !sedge
      |=> serial_data_oe && serial_data_out) else $error("ready status lost");
endmodule : see_engine_chk

bind see_engine see_engine_chk #(.ALL_CYCLES(ALL_CYCLES)) see_engine_chk_i (
   .ref_clk(ref_clk), .reset_n(reset_n), .chip_sel(chip_sel), .serial_clk(serial_clk),
   .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
   .serial_data_oe(serial_data_oe));

// ===== testbench/test_serial_eeprom_instruction_engine.sv
// Bench: host model drives the engine; a word-array model gives expectations.
// Assumes short programming counts set through the engine parameters.
`timescale 1ns/100ps
`define SEE_CHK(a, e) begin num_checks++; if ((a) !== (e)) begin bad_count++; \
   $display("ERROR %0t got %h want %h", $time, a, e); end end
module test_serial_eeprom_instruction_engine;
   import see_pkg::*;
   logic ref_clk = 1'b0;
   logic reset_n = 1'b0;
   logic chip_sel, serial_clk, serial_data_in, serial_data_out, serial_data_oe;
   int bad_count = 0;
   int num_checks = 0;
   int cyc = 0;
   logic [15:0] mem [64];
   logic en = 1'b0;
   logic [31:0] dq, eq;
   logic [5:0] wa;
   logic [15:0] wd;
   always #25 ref_clk = ~ref_clk;
   see_engine #(.WRITE_CYCLES(19'h3C), .ERASE_CYCLES(19'h28), .ALL_CYCLES(19'h96)) see_engine_i (
      .ref_clk(ref_clk), .reset_n(reset_n), .chip_sel(chip_sel), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe));
   see_host see_host_i (.ref_clk(ref_clk), .chip_sel(chip_sel), .serial_clk(serial_clk),
      .serial_data_in(serial_data_in), .serial_data_out(serial_data_out),
      .serial_data_oe(serial_data_oe));
   task automatic stop_test();
      $display("checks %0d errors %0d", num_checks, bad_count);
      if (bad_count == 0 && num_checks > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask : stop_test
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (cyc == 30000) begin
         bad_count++;
         stop_test();
      end
   end
   // One instruction of n clocks, status poll, model update
   task automatic op(input logic [1:0] o, input logic [5:0] a, input logic [15:0] d,
         input int n, input int lim);
      int need;
      int k;
      logic prog;
      need = (o == 2'h1 || (o == 2'h0 && a[5:4] == 2'h1)) ? 25 : 9;
      prog = en && n >= need && (o[0] || (o == 2'h0 && a[5] != a[4]));
      see_host_i.shift({1'b1, o, a, d, 7'h00}, n, dq, eq);
      if (o == 2'h2 && n == 26) begin
         `SEE_CHK(eq[23] && !dq[23], 1'b1)
         `SEE_CHK({dq[22:7], eq[22:7]}, {mem[a], 16'hFFFF})
         `SEE_CHK(eq[6], 1'b0)
      end
      see_host_i.drop();
      `SEE_CHK(serial_data_oe, 1'b0)
      see_host_i.shift(32'h0, 0, dq, eq);
      repeat (2) @(posedge ref_clk);
      #1;
      `SEE_CHK({serial_data_oe, serial_data_out & prog}, {prog, 1'b0})
      k = 0;
      while (serial_data_oe === 1'b1 && serial_data_out !== 1'b1 && k < 400) begin
         @(posedge ref_clk);
         #1;
         k++;
      end
      if (prog) `SEE_CHK({serial_data_out, k < lim}, 2'h3)
      see_host_i.drop();
      if (prog) begin
         if (o == 2'h1) mem[a] = d;
         if (o == 2'h3) mem[a] = 16'hFFFF;
         for (int i = 0; i < 64; i++) begin
            if (o == 2'h0) mem[i] = a[4] ? mem[i] & d : 16'hFFFF;
         end
      end
      if (o == 2'h0 && n >= 9 && a[5] == a[4]) en = a[5];
   endtask : op
   initial begin
      void'($urandom(3));
      repeat (20) @(posedge ref_clk);
      reset_n <= 1'b1;
      repeat (2) @(posedge ref_clk);
      op(2'h1, 6'h05, 16'h1234, 25, 60);
      op(2'h0, 6'h30, 16'h0000, 9, 0);
      op(2'h0, 6'h20, 16'h0000, 9, 150);
      op(2'h2, 6'h3F, 16'h0000, 26, 0);
      op(2'h0, 6'h10, 16'($urandom), 25, 150);
      op(2'h2, 6'h00, 16'h0000, 26, 0);
      for (int i = 0; i < 5; i++) begin
         wa = 6'($urandom);
         wd = 16'($urandom);
         op(2'h1, wa, wd, 25, 60);
         op(2'h2, wa, 16'h0000, 26, 0);
         op(2'h1, wa, ~wd, 25, 60);
         op(2'h2, wa, 16'h0000, 26, 0);
         op(2'h3, wa, 16'h0000, 12, 40);
         op(2'h2, wa, 16'h0000, 26, 0);
      end
      op(2'h1, wa, 16'h0F0F, 20, 60);
      op(2'h2, wa, 16'h0000, 14, 0);
      op(2'h0, 6'h00, 16'h0000, 9, 0);
      op(2'h1, wa, 16'h0000, 25, 60);
      op(2'h2, wa, 16'h0000, 26, 0);
      stop_test();
   end
endmodule : test_serial_eeprom_instruction_engine
